// ===== common/flash_ctrl_regs.svh
// timing constants for the parallel flash host controller
`ifndef FLASH_CTRL_REGS_SVH
`define FLASH_CTRL_REGS_SVH

`define CLK_PERIOD_NS      25
`define T_RESET_LOW_NS     500
`define T_RESET_LOW_CYC    ((`T_RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_READY_US         20
`define T_READY_CYC        ((`T_READY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RH_NS            50
`define T_RH_CYC           ((`T_RH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_BUSY_NS          90
`define T_BUSY_CYC         ((`T_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_ACC_CYC          4
`define T_WP_CYC           2
`define POLL_BIT           7
`define TOGGLE_BIT         6
`define SECTOR_LSB         16
`define SECTOR_MSB         20
`define ERASED_BYTE        8'hff

`endif

// ===== common/flash_ctrl_pkg.sv
// types for the parallel flash host controller
package flash_ctrl_pkg;

    typedef enum logic [1:0] {
        OP_PROGRAM,
        OP_CHIP_ERASE,
        OP_SECTOR_ERASE,
        OP_READ
    } flash_op_t;

    typedef struct packed {
        flash_op_t   op;
        logic [20:0] addr;
        logic [7:0]  data;
    } flash_req_t;

    typedef struct packed {
        logic [20:0] addr;
        logic [7:0]  dout;
        logic        dout_en;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        reset_n;
    } flash_pins_t;

endpackage : flash_ctrl_pkg

// ===== rtl/flash_bus_cycle.sv
// one timed read or write cycle on the flash pins
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_regs.svh"

module flash_bus_cycle
    import flash_ctrl_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        start_i,
    input  wire logic        write_i,
    input  wire logic [20:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic [7:0]  din_i,
    output logic             done_o,
    output logic [7:0]       rdata_o,
    output logic [20:0]      addr_o,
    output logic [7:0]       dout_o,
    output logic             dout_en_o,
    output logic             ce_n_o,
    output logic             oe_n_o,
    output logic             we_n_o
);

    // ========================================================
    // cycle timer
    logic [2:0]  cnt_q, cnt_d;
    logic        act_q, act_d, wr_q, wr_d, done_q, done_d;
    logic [20:0] addr_q, addr_d;
    logic [7:0]  wd_q, wd_d, rd_q, rd_d;

    // next values of the cycle
    always_comb begin
        cnt_d  = cnt_q;
        act_d  = act_q;
        wr_d   = wr_q;
        addr_d = addr_q;
        wd_d   = wd_q;
        rd_d   = rd_q;
        done_d = 1'b0;
        if (!act_q && start_i) begin
            act_d  = 1'b1;
            wr_d   = write_i;
            addr_d = addr_i;
            wd_d   = wdata_i;
            cnt_d  = '0;
        end else if (act_q) begin
            cnt_d = cnt_q + 3'h1;
            if (wr_q ? (cnt_q == 3'(`T_WP_CYC))
                     : (cnt_q == 3'(`T_ACC_CYC))) begin
                act_d  = 1'b0;
                done_d = 1'b1;
                if (!wr_q) rd_d = din_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q  <= '0;
            act_q  <= 1'b0;
            wr_q   <= 1'b0;
            done_q <= 1'b0;
            addr_q <= '0;
            wd_q   <= '0;
            rd_q   <= '0;
        end else begin
            cnt_q  <= cnt_d;
            act_q  <= act_d;
            wr_q   <= wr_d;
            done_q <= done_d;
            addr_q <= addr_d;
            wd_q   <= wd_d;
            rd_q   <= rd_d;
        end
    end

    // pin drive; we low only inside the pulse, data held one cycle past
    assign done_o    = done_q;
    assign rdata_o   = rd_q;
    assign addr_o    = addr_q;
    assign dout_o    = wd_q;
    assign dout_en_o = act_q && wr_q;
    assign ce_n_o    = !act_q;
    assign oe_n_o    = !(act_q && !wr_q);
    assign we_n_o    = !(act_q && wr_q && cnt_q != 3'(`T_WP_CYC));

endmodule : flash_bus_cycle
`default_nettype wire

// ===== rtl/flash_host_ctrl.sv
// host controller: issues program and erase, polls status, hard reset
//
// Notes on behaviour
// R1 - device programs and verifies one byte; host runs no verify loop
// R2 - during program, poll bit reads inverse of written bit 7
// R3 - bit 6 toggles during program and erase as a status bit
// R4 - host polls status until done before any normal read
// R5 - chip erase erases and verifies everything internally
// R6 - poll bit reads 0 while erasing, 1 when done
// R7 - sector erase carries the sector on address bits 16 to 20
// R8 - device aborts within 20 us after reset pin goes low
// R9 - host holds reset pin low at least 500 ns
// R10 - host waits at least 50 ns after reset release before reading
// R11 - ready/busy goes low within 90 ns of a valid command
// R12 - toggle bit flips every read while busy, then array data returns
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_regs.svh"

module flash_host_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int unsigned READY_CYC = `T_READY_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire flash_req_t  req_i,
    input  wire logic        hard_reset_i,
    output logic             done_o,
    output logic [7:0]       rdata_o,
    output logic             busy_o,
    input  wire logic [7:0]  flash_din_i,
    input  wire logic        ready_busy_n_i,
    output flash_pins_t      flash_o
);

    // ========================================================
    // sequencer state
    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_CMD_WAIT, ST_POLL, ST_POLL_WAIT,
        ST_READ_WAIT, ST_RST_LOW, ST_RST_REC
    } seq_state_t;

    seq_state_t  st_q, st_d;
    flash_req_t  req_q, req_d;
    logic [2:0]  step_q, step_d;
    logic [2:0]  nsteps;
    logic        tog_vld_q, tog_vld_d, tog_q, tog_d;
    logic        done_q, done_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [15:0] tmr_q, tmr_d;
    logic        cyc_start, cyc_write, cyc_done;
    logic [20:0] cyc_addr;
    logic [7:0]  cyc_wdata, cyc_rdata;
    logic [20:0] pin_addr;
    logic [7:0]  pin_dout;
    logic        pin_den, pin_ce_n, pin_oe_n, pin_we_n;
    logic        poll_ok;

    // ========================================================
    // unlock and command write table
    always_comb begin
        nsteps    = (req_q.op == OP_PROGRAM) ? 3'h4 : 3'h6;
        cyc_addr  = 21'h000000;
        cyc_wdata = 8'h00;
        case (step_q)
            3'h0: begin cyc_addr = 21'h000aaa; cyc_wdata = 8'haa; end
            3'h1: begin cyc_addr = 21'h000555; cyc_wdata = 8'h55; end
            3'h2: begin
                cyc_addr  = 21'h000aaa;
                cyc_wdata = (req_q.op == OP_PROGRAM) ? 8'ha0 : 8'h80;
            end
            3'h3: begin
                if (req_q.op == OP_PROGRAM) begin
                    cyc_addr  = req_q.addr;   // one byte, device verifies [R1]
                    cyc_wdata = req_q.data;
                end else begin
                    cyc_addr  = 21'h000aaa;
                    cyc_wdata = 8'haa;
                end
            end
            3'h4: begin cyc_addr = 21'h000555; cyc_wdata = 8'h55; end
            3'h5: begin
                if (req_q.op == OP_SECTOR_ERASE) begin
                    cyc_addr  = {req_q.addr[`SECTOR_MSB:`SECTOR_LSB],
                                 16'h0000};   // sector select [R7]
                    cyc_wdata = 8'h30;
                end else begin
                    cyc_addr  = 21'h000aaa;   // whole array [R5]
                    cyc_wdata = 8'h10;
                end
            end
            default: begin
                cyc_addr  = req_q.addr;
                cyc_wdata = 8'h00;
            end
        endcase
        // a read starts from idle, before req_q holds the new request
        if (st_q == ST_IDLE)
            cyc_addr = req_i.addr;
        else if (st_q == ST_POLL || st_q == ST_POLL_WAIT ||
                 st_q == ST_READ_WAIT)
            cyc_addr = req_q.addr;
    end

    // poll bit: program expects true bit 7, erase expects 1 [R2] [R6]
    assign poll_ok = (req_q.op == OP_PROGRAM)
        ? (cyc_rdata[`POLL_BIT] == req_q.data[`POLL_BIT])
        : cyc_rdata[`POLL_BIT];

    // ========================================================
    // sequencer next state
    always_comb begin
        st_d      = st_q;
        req_d     = req_q;
        step_d    = step_q;
        tog_vld_d = tog_vld_q;
        tog_d     = tog_q;
        done_d    = 1'b0;
        rdata_d   = rdata_q;
        tmr_d     = tmr_q;
        cyc_start = 1'b0;
        cyc_write = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (hard_reset_i) begin
                    st_d  = ST_RST_LOW;
                    tmr_d = '0;
                end else if (req_valid_i) begin
                    req_d = req_i;
                    step_d = '0;
                    tog_vld_d = 1'b0;
                    if (req_i.op == OP_READ) begin
                        st_d = ST_READ_WAIT;
                        cyc_start = 1'b1;
                    end else begin
                        st_d = ST_CMD;
                    end
                end
            end
            ST_CMD: begin
                cyc_start = 1'b1;
                cyc_write = 1'b1;
                st_d = ST_CMD_WAIT;
            end
            ST_CMD_WAIT: begin
                if (cyc_done) begin
                    step_d = step_q + 3'h1;
                    st_d = (step_q == nsteps - 3'h1) ? ST_POLL : ST_CMD;
                    tmr_d = '0;
                end
            end
            ST_POLL: begin
                // let ready/busy settle before the first status read [R11]
                if (tmr_q >= 16'(`T_BUSY_CYC)) begin
                    cyc_start = 1'b1;
                    st_d = ST_POLL_WAIT;
                end else begin
                    tmr_d = tmr_q + 16'h0001;
                end
            end
            ST_POLL_WAIT: begin
                // keep reading status until both checks agree [R4]
                if (cyc_done) begin
                    tog_vld_d = 1'b1;
                    tog_d = cyc_rdata[`TOGGLE_BIT];
                    if (poll_ok && tog_vld_q &&
                        cyc_rdata[`TOGGLE_BIT] == tog_q) begin  // [R3] [R12]
                        st_d = ST_IDLE;
                        done_d = 1'b1;
                        rdata_d = cyc_rdata;
                    end else begin
                        st_d = ST_POLL;
                    end
                end
            end
            ST_READ_WAIT: begin
                if (cyc_done) begin
                    st_d = ST_IDLE;
                    done_d = 1'b1;
                    rdata_d = cyc_rdata;
                end
            end
            ST_RST_LOW: begin
                // hold reset low long enough for abort [R9] [R8]
                if (tmr_q >= 16'(`T_RESET_LOW_CYC) &&
                    tmr_q >= 16'(READY_CYC)) begin
                    st_d = ST_RST_REC;
                    tmr_d = '0;
                end else begin
                    tmr_d = tmr_q + 16'h0001;
                end
            end
            ST_RST_REC: begin
                // recovery before the next read access [R10]
                if (tmr_q >= 16'(`T_RH_CYC)) begin
                    st_d = ST_IDLE;
                    done_d = 1'b1;
                end else begin
                    tmr_d = tmr_q + 16'h0001;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q      <= ST_IDLE;
            req_q     <= '0;
            step_q    <= '0;
            tog_vld_q <= 1'b0;
            tog_q     <= 1'b0;
            done_q    <= 1'b0;
            rdata_q   <= '0;
            tmr_q     <= '0;
        end else begin
            st_q      <= st_d;
            req_q     <= req_d;
            step_q    <= step_d;
            tog_vld_q <= tog_vld_d;
            tog_q     <= tog_d;
            done_q    <= done_d;
            rdata_q   <= rdata_d;
            tmr_q     <= tmr_d;
        end
    end

    // ========================================================
    // pin cycle engine
    flash_bus_cycle u_cycle (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .start_i   (cyc_start),
        .write_i   (cyc_write),
        .addr_i    (cyc_addr),
        .wdata_i   (cyc_wdata),
        .din_i     (flash_din_i),
        .done_o    (cyc_done),
        .rdata_o   (cyc_rdata),
        .addr_o    (pin_addr),
        .dout_o    (pin_dout),
        .dout_en_o (pin_den),
        .ce_n_o    (pin_ce_n),
        .oe_n_o    (pin_oe_n),
        .we_n_o    (pin_we_n)
    );

    // outputs
    always_comb begin
        flash_o.addr    = pin_addr;
        flash_o.dout    = pin_dout;
        flash_o.dout_en = pin_den;
        flash_o.ce_n    = pin_ce_n;
        flash_o.oe_n    = pin_oe_n;
        flash_o.we_n    = pin_we_n;
        flash_o.reset_n = (st_q != ST_RST_LOW);   // [R9]
    end

    assign req_ready_o = (st_q == ST_IDLE) && !hard_reset_i;
    assign done_o      = done_q;
    assign rdata_o     = rdata_q;
    assign busy_o      = (st_q != ST_IDLE) || !ready_busy_n_i;

endmodule : flash_host_ctrl
`default_nettype wire

// ===== test/flash_host_ctrl_properties.sv
// port assertions for the flash host controller
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl_properties
    import flash_ctrl_pkg::*;
#(
    parameter int unsigned READY_CYC = 800
) (
    input wire logic        clk_sys_i,
    input wire logic        reset_n_i,
    input wire logic        req_valid_i,
    input wire logic        req_ready_o,
    input wire flash_req_t  req_i,
    input wire logic        done_o,
    input wire logic        busy_o,
    input wire logic        ready_busy_n_i,
    input wire flash_pins_t flash_o
);
    // ==========
    // flash reset pin low time
    logic [15:0] low_q;
    logic [15:0] low_d;

    // count cycles with the reset pin low
    always_comb low_d = flash_o.reset_n ? 16'h0 : low_q + 16'h1;
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i)
            low_q <= 16'h0;
        else
            low_q <= low_d;
    end

    // ==========
    // properties
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    chk_busy_pin: assert property (
        !ready_busy_n_i |-> busy_o && !req_ready_o)
        else $error("busy pin not reflected");
    chk_done_pulse: assert property (
        done_o |=> !done_o)
        else $error("done longer than one cycle");
    chk_read_time: assert property (
        req_valid_i && req_ready_o && req_i.op == OP_READ
        |=> !done_o [*6] ##1 done_o)
        else $error("read done not at seven cycles");
    chk_reset_width: assert property (
        $rose(flash_o.reset_n) |-> low_q >= 16'h14)
        else $error("reset pulse too short");
    chk_reset_abort: assert property (
        $rose(flash_o.reset_n) |-> low_q >= 16'(READY_CYC))
        else $error("reset pulse shorter than abort time");
    chk_busy_taken: assert property (
        req_valid_i && req_ready_o |=> busy_o)
        else $error("busy not raised after request");
    chk_reset_gap: assert property (
        $rose(flash_o.reset_n) |-> flash_o.oe_n [*2])
        else $error("read too soon after reset");
    chk_reset_quiet: assert property (
        !flash_o.reset_n |-> !req_ready_o && flash_o.we_n && flash_o.ce_n)
        else $error("bus active during reset");
    chk_no_clash: assert property (
        !flash_o.oe_n |-> !flash_o.dout_en)
        else $error("host drives data while reading");
    chk_write_width: assert property (
        $fell(flash_o.we_n) |-> !flash_o.ce_n && flash_o.dout_en
        ##1 !flash_o.we_n)
        else $error("write pulse too short");
endmodule // flash_host_ctrl_properties
`default_nettype wire

// ===== test/flash_dev_model.sv
// behavioural parallel flash device
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model
    import flash_ctrl_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire flash_pins_t pins_i,
    input  wire logic [15:0] busy_len_i,
    output logic [7:0]       din_o,
    output logic             ready_busy_n_o
);
    logic [7:0]  mem [int];
    logic [7:0]  last_q = 8'h00;
    logic [7:0]  pd_q = 8'h00;
    logic        busy_q = 1'b0;
    logic        erase_q = 1'b0;
    logic        tog_q = 1'b0;
    logic        we_q = 1'b1;
    logic        oe_q = 1'b1;
    logic        go;
    logic [2:0]  step_q = 3'h0;
    logic [15:0] cnt_q = 16'h0;
    logic [7:0]  d;
    logic [20:0] a;

    // pin low for the whole embedded operation
    assign ready_busy_n_o = !busy_q;

    // status while busy, array data after, stale inverse when released
    always_comb begin
        if (!pins_i.ce_n && !pins_i.oe_n && busy_q)
            din_o = {erase_q ? 1'b0 : !pd_q[7], tog_q, 6'h15};
        else if (!pins_i.ce_n && !pins_i.oe_n)
            din_o = mem.exists(int'(pins_i.addr)) ?
                    mem[int'(pins_i.addr)] : 8'hff;
        else
            din_o = ~last_q;
    end

    // command decode and operation timer
    always @(posedge clk_sys_i) begin
        a = pins_i.addr;
        d = pins_i.dout;
        go = 1'b0;
        we_q <= pins_i.we_n;
        oe_q <= pins_i.oe_n;
        last_q <= din_o;
        cnt_q <= cnt_q - 16'h1;
        if (busy_q && cnt_q == 16'h1)
            busy_q <= 1'b0;
        if (busy_q && oe_q && !pins_i.oe_n && !pins_i.ce_n)
            tog_q <= !tog_q;
        if (!we_q && pins_i.we_n && !pins_i.ce_n) begin
            step_q <= 3'h0;
            case (step_q)
                3'h0: if (d == 8'haa) step_q <= 3'h1;
                3'h1: if (d == 8'h55) step_q <= 3'h2;
                3'h2: step_q <= d == 8'ha0 ? 3'h3 : d == 8'h80 ? 3'h4 : 3'h0;
                3'h3: begin
                    mem[int'(a)] = d;
                    pd_q <= d;
                    erase_q <= 1'b0;
                    go = 1'b1;
                end
                3'h4: if (d == 8'haa) step_q <= 3'h5;
                3'h5: if (d == 8'h55) step_q <= 3'h6;
                default: begin
                    if (d == 8'h10)
                        mem.delete();
                    if (d == 8'h30)
                        foreach (mem[k])
                            if (k[20:16] == a[20:16]) mem[k] = 8'hff;
                    erase_q <= 1'b1;
                    go = d == 8'h10 || d == 8'h30;
                end
            endcase
        end
        if (go) begin
            busy_q <= 1'b1;
            cnt_q <= busy_len_i;
        end
        if (!pins_i.reset_n) begin
            busy_q <= 1'b0;
            step_q <= 3'h0;
        end
    end
endmodule // flash_dev_model
`default_nettype wire

// ===== test/tb_flash_host_ctrl.sv
// self-checking bench for the flash host controller
`timescale 1ns/100ps
`default_nettype none
module tb_flash_host_ctrl
    import flash_ctrl_pkg::*;
;
    logic        clk_sys_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        req_valid_i = 1'b0;
    logic        hard_reset_i = 1'b0;
    flash_req_t  req_i = '0;
    logic        req_ready_o;
    logic        done_o;
    logic        busy_o;
    logic        ready_busy_n_i;
    logic [7:0]  rdata_o;
    logic [7:0]  flash_din_i;
    flash_pins_t flash_o;
    logic [15:0] busy_len = 16'h28;
    logic [8:0]  exp_q [$];
    logic [8:0]  note;
    logic [20:0] a;
    logic [7:0]  d;
    int          error_cnt = 0;
    int          compares = 0;
    int          seed = 32'hfc861463;

    always #12.5 clk_sys_i = !clk_sys_i;

    flash_host_ctrl #(.READY_CYC(4)) uut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
        .hard_reset_i(hard_reset_i), .done_o(done_o), .rdata_o(rdata_o),
        .busy_o(busy_o), .flash_din_i(flash_din_i),
        .ready_busy_n_i(ready_busy_n_i), .flash_o(flash_o));
    flash_dev_model dev (
        .clk_sys_i(clk_sys_i), .pins_i(flash_o), .busy_len_i(busy_len),
        .din_o(flash_din_i), .ready_busy_n_o(ready_busy_n_i));

    // ==========
    // tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done_o !== 1'b1 && n < 4000) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 4000) error_cnt++;
        #1;
    endtask

    // hold the request until taken, then wait for its result
    task automatic issue(input flash_op_t op, input logic [20:0] ad,
                         input logic [7:0] dt, input logic [8:0] nt);
        int n;
        n = 0;
        req_i = '{op: op, addr: ad, data: dt};
        req_valid_i = 1'b1;
        exp_q.push_back(nt);
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (req_ready_o !== 1'b1 && n < 100);
        if (n >= 100) error_cnt++;
        #1 req_valid_i = 1'b0;
        wait_done();
    endtask

    // ==========
    // result monitor: oldest note against each result
    always @(posedge clk_sys_i) begin
        if (reset_n_i && done_o === 1'b1) begin
            check(8'(exp_q.size() > 0), 8'h01);
            if (exp_q.size() > 0) begin
                note = exp_q.pop_front();
                if (note[8]) check(rdata_o, note[7:0]);
            end
        end
    end

    // ==========
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys_i);
        #1 reset_n_i = 1'b1;
        // program then read back, slow and prompt device
        for (int i = 0; i < 6; i++) begin
            busy_len = i[0] ? 16'h2 : 16'h28;
            a = 21'($random(seed));
            d = 8'($random(seed));
            issue(OP_PROGRAM, a, d, {1'b1, d});
            issue(OP_READ, a, 8'h00, {1'b1, d});
        end
        // sector erase spares the sector with inverted bits 20 to 16, chip erase then clears it
        issue(OP_PROGRAM, {~a[20:16], a[15:0]}, 8'h5a, 9'h15a);
        issue(OP_SECTOR_ERASE, a, 8'h00, 9'h1ff);
        issue(OP_READ, a, 8'h00, 9'h1ff);
        issue(OP_READ, {~a[20:16], a[15:0]}, 8'h00, 9'h15a);
        issue(OP_CHIP_ERASE, 21'h0, 8'h00, 9'h1ff);
        issue(OP_READ, {~a[20:16], a[15:0]}, 8'h00, 9'h1ff);
        // hard reset, then program and read again
        hard_reset_i = 1'b1;
        exp_q.push_back(9'h000);
        @(posedge clk_sys_i);
        #1 hard_reset_i = 1'b0;
        wait_done();
        issue(OP_PROGRAM, a, 8'h81, 9'h181);
        issue(OP_READ, a, 8'h00, 9'h181);
        check(8'(exp_q.size()), 8'h00);
        end_sim();
    end

    // watchdog
    initial begin
        #(25 * 40000);
        error_cnt++;
        end_sim();
    end
endmodule // tb_flash_host_ctrl

bind flash_host_ctrl flash_host_ctrl_properties #(.READY_CYC(READY_CYC)) chk (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_i(req_i), .done_o(done_o),
    .busy_o(busy_o), .ready_busy_n_i(ready_busy_n_i), .flash_o(flash_o));
`default_nettype wire
